// File: hw/step_seq_pkg.sv
// Shared constants, types and register map of the stepper sequencer
package step_seq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_FWD_PHASE = 10'h045;
  localparam logic [9:0] IDX_PWM_FREQ = 10'h056;
  localparam logic [9:0] IDX_PWM_MIN_ON = 10'h057;
  localparam logic [9:0] IDX_MOTOR_CTRL = 10'h060;
  localparam logic [9:0] IDX_STEP_SIZE = 10'h061;
  localparam logic [9:0] IDX_CURRENT = 10'h062;
  localparam logic [9:0] IDX_PAUSE = 10'h063;
  localparam logic [9:0] IDX_RESYNC = 10'h064;
  localparam logic [9:0] IDX_STATUS = 10'h065;

  // Field positions
  localparam int CMD_LSB = 0;
  localparam int MICRO_BIT = 2;
  localparam int PIXRATE_BIT = 3;
  localparam int KICK_LSB = 0;
  localparam int HOLD_LSB = 8;
  localparam int AFTER_PAUSE_LSB = 0;
  localparam int DISCARD_LSB = 8;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [13:0] RST_STEP_SIZE = 14'h0001;
  localparam logic [4:0] RST_HOLD = 5'h01;
  localparam logic [13:0] RST_RESYNC = 14'h0000;

  // Pixel period in master clocks
  localparam logic [4:0] PIX_DIV_PIXRATE = 5'h18;
  localparam logic [4:0] PIX_DIV_LINERATE = 5'h08;

  // Microsteps per full step, minus one
  localparam logic [1:0] MICRO_PER_FULL_M1 = 2'h3;
  // Quarter of the electrical cycle in microsteps
  localparam logic [3:0] QUARTER = 4'h4;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_SCAN = 2'b01,
    CMD_FEED_FWD = 2'b10,
    CMD_FEED_REV = 2'b11
  } motor_cmd_t;

  // Full step current reference codes
  typedef enum logic [1:0] {
    DAC_ZERO = 2'b00,
    DAC_HOLD = 2'b01,
    DAC_SCAN = 2'b10,
    DAC_KICK = 2'b11
  } full_dac_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_DRAIN = 3'b010,
    ST_PAUSED = 3'b011,
    ST_SYNC_WAIT = 3'b100,
    ST_SYNC_DELAY = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic fwd_b_leads;
    logic [7:0] pwm_period;
    logic [7:0] pwm_min_on;
    motor_cmd_t cmd;
    logic micro_mode;
    logic pixel_rate;
    logic [13:0] step_size;
    logic [2:0] kick_steps;
    logic [4:0] hold_steps;
    logic [2:0] lines_after_pause;
    logic [2:0] lines_discard;
    logic [13:0] resync_pixels;
  } seq_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
    logic a_n;
    logic b_n;
  } phase_t;

endpackage

// File: hw/motor_pwm.sv
// Fixed-period PWM that holds winding current at the reference
`timescale 1ns/1ps
module motor_pwm import step_seq_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Control
  input wire logic i_enable,
  input wire logic [WIDTH-1:0] i_period,
  input wire logic [WIDTH-1:0] i_min_on,
  input wire logic i_over_current,
  // Drive gate
  output logic o_drive
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic on_reg;
  logic on_next;

  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    on_next = on_reg;
    if (!i_enable) begin
      cnt_next = '0;
      on_next = 1'b0;
    end else if (cnt_reg >= i_period) begin
      cnt_next = '0;
      on_next = 1'b1;
    end else if (cnt_reg >= i_min_on && i_over_current) begin
      // Before min-on the comparator sees switching noise only
      on_next = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= '0;
      on_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      on_reg <= on_next;
    end
  end

  assign o_drive = on_reg;

endmodule

// File: hw/stepper_motor_step_sequencer.sv
// Stepper motor step sequencer with APB registers
`timescale 1ns/1ps
module stepper_motor_step_sequencer import step_seq_pkg::*; #(
  parameter int STEP_W = 14
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // Line buffer and timing
  input wire logic i_pause_req,
  input wire logic i_resume_req,
  input wire logic i_line_transfer_pulse,
  // Current sense comparator pin
  input wire logic i_over_current,
  // Motor driver
  output logic o_phase_a,
  output logic o_phase_b,
  output logic o_phase_a_n,
  output logic o_phase_b_n,
  output logic [1:0] o_full_dac,
  output logic [1:0] o_micro_dac,
  // Line path control
  output logic o_line_store,
  output logic o_line_discard
);

  // Index into the register map; misaligned addresses hit nothing
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[11:2] == idx);
  endfunction

  // Signed sine table index for a position in the 16-microstep cycle
  function automatic logic signed [3:0] tri_idx(input logic [3:0] p);
    if (p <= 4'd4) begin
      tri_idx = signed'(p);
    end else if (p <= 4'd8) begin
      tri_idx = signed'(4'd8 - p);
    end else if (p <= 4'd12) begin
      tri_idx = -signed'(p - 4'd8);
    end else begin
      tri_idx = -signed'(4'd0 - p);
    end
  endfunction

  // Registers
  seq_cfg_t cfg_reg;
  seq_cfg_t cfg_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic err_reg;
  logic err_next;

  // Engine state
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [4:0] pix_cnt_reg;
  logic [4:0] pix_cnt_next;
  logic [STEP_W-1:0] step_cnt_reg;
  logic [STEP_W-1:0] step_cnt_next;
  logic [3:0] pos_reg;
  logic [3:0] pos_next;
  logic [1:0] sub_reg;
  logic [1:0] sub_next;
  logic [2:0] kick_reg;
  logic [2:0] kick_next;
  logic [4:0] hold_reg;
  logic [4:0] hold_next;
  logic moving_reg;
  logic moving_next;
  logic [2:0] lines_reg;
  logic [2:0] lines_next;
  logic [2:0] discard_reg;
  logic [2:0] discard_next;
  logic [STEP_W-1:0] sync_reg;
  logic [STEP_W-1:0] sync_next;
  logic resume_pend_reg;
  logic resume_pend_next;
  phase_t phase_reg;
  phase_t phase_next;
  full_dac_t fdac_reg;
  full_dac_t fdac_next;
  logic [1:0] mdac_reg;
  logic [1:0] mdac_next;

  // Sense pin synchroniser and filter
  logic sense_s1_reg;
  logic sense_s2_reg;
  logic sense_s3_reg;
  logic sense_reg;
  logic sense_next;

  logic pwm_drive;
  logic pix_tick;
  logic micro_tick;
  logic full_tick;
  logic moving;
  logic powered;
  logic [4:0] pix_div;
  logic [STEP_W-1:0] step_last;
  logic signed [3:0] idx_a;
  logic signed [3:0] idx_b;
  logic [3:0] pos_b;
  logic [3:0] pos_eff;
  logic [3:0] mag_a;
  logic [3:0] mag_b;

  // APB register file; no wait states
  always_comb begin
    cfg_next = cfg_reg;
    prdata_next = prdata_reg;
    err_next = 1'b0;
    if (i_psel && !i_penable) begin
      prdata_next = 32'h0000_0000;
      err_next = 1'b0;
      if (hit(i_paddr, IDX_FWD_PHASE)) begin
        prdata_next[0] = cfg_reg.fwd_b_leads;
      end else if (hit(i_paddr, IDX_PWM_FREQ)) begin
        prdata_next[7:0] = cfg_reg.pwm_period;
      end else if (hit(i_paddr, IDX_PWM_MIN_ON)) begin
        prdata_next[7:0] = cfg_reg.pwm_min_on;
      end else if (hit(i_paddr, IDX_MOTOR_CTRL)) begin
        prdata_next[CMD_LSB+:2] = cfg_reg.cmd;
        prdata_next[MICRO_BIT] = cfg_reg.micro_mode;
        prdata_next[PIXRATE_BIT] = cfg_reg.pixel_rate;
      end else if (hit(i_paddr, IDX_STEP_SIZE)) begin
        prdata_next[STEP_W-1:0] = cfg_reg.step_size;
      end else if (hit(i_paddr, IDX_CURRENT)) begin
        prdata_next[KICK_LSB+:3] = cfg_reg.kick_steps;
        prdata_next[HOLD_LSB+:5] = cfg_reg.hold_steps;
      end else if (hit(i_paddr, IDX_PAUSE)) begin
        prdata_next[AFTER_PAUSE_LSB+:3] = cfg_reg.lines_after_pause;
        prdata_next[DISCARD_LSB+:3] = cfg_reg.lines_discard;
      end else if (hit(i_paddr, IDX_RESYNC)) begin
        prdata_next[STEP_W-1:0] = cfg_reg.resync_pixels;
      end else if (hit(i_paddr, IDX_STATUS)) begin
        prdata_next[2:0] = state_reg;
        prdata_next[7:4] = pos_reg;
        prdata_next[8] = powered;
        prdata_next[9] = moving_reg;
        prdata_next[14:12] = kick_reg;
        prdata_next[20:16] = hold_reg;
      end else begin
        err_next = 1'b1;
      end
    end else if (i_psel && i_penable) begin
      err_next = err_reg;
      if (i_pwrite) begin
        if (hit(i_paddr, IDX_FWD_PHASE)) begin
          cfg_next.fwd_b_leads = i_pwdata[0];
        end else if (hit(i_paddr, IDX_PWM_FREQ)) begin
          cfg_next.pwm_period = i_pwdata[7:0];
        end else if (hit(i_paddr, IDX_PWM_MIN_ON)) begin
          cfg_next.pwm_min_on = i_pwdata[7:0];
        end else if (hit(i_paddr, IDX_MOTOR_CTRL)) begin
          cfg_next.cmd = motor_cmd_t'(i_pwdata[CMD_LSB+:2]);
          cfg_next.micro_mode = i_pwdata[MICRO_BIT];
          cfg_next.pixel_rate = i_pwdata[PIXRATE_BIT];
        end else if (hit(i_paddr, IDX_STEP_SIZE)) begin
          cfg_next.step_size = i_pwdata[STEP_W-1:0];
        end else if (hit(i_paddr, IDX_CURRENT)) begin
          cfg_next.kick_steps = i_pwdata[KICK_LSB+:3];
          cfg_next.hold_steps = i_pwdata[HOLD_LSB+:5];
        end else if (hit(i_paddr, IDX_PAUSE)) begin
          cfg_next.lines_after_pause = i_pwdata[AFTER_PAUSE_LSB+:3];
          cfg_next.lines_discard = i_pwdata[DISCARD_LSB+:3];
        end else if (hit(i_paddr, IDX_RESYNC)) begin
          cfg_next.resync_pixels = i_pwdata[STEP_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_reg <= '{fwd_b_leads: 1'b0, pwm_period: RST_BYTE, pwm_min_on: RST_BYTE,
                   cmd: CMD_IDLE, micro_mode: 1'b0, pixel_rate: 1'b0,
                   step_size: RST_STEP_SIZE, kick_steps: 3'h0, hold_steps: RST_HOLD,
                   lines_after_pause: 3'h0, lines_discard: 3'h0,
                   resync_pixels: RST_RESYNC};
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && err_reg;
  assign o_prdata = prdata_reg;

  // Sense pin: first stage feeds only the second
  always_comb begin
    sense_next = sense_reg;
    if (sense_s2_reg == sense_s3_reg) begin
      sense_next = sense_s3_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sense_s1_reg <= 1'b0;
      sense_s2_reg <= 1'b0;
      sense_s3_reg <= 1'b0;
      sense_reg <= 1'b0;
    end else begin
      sense_s1_reg <= i_over_current;
      sense_s2_reg <= sense_s1_reg;
      sense_s3_reg <= sense_s2_reg;
      sense_reg <= sense_next;
    end
  end

  motor_pwm #(.WIDTH(8)) u_pwm (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_enable(cfg_reg.micro_mode && powered),
    .i_period(cfg_reg.pwm_period),
    .i_min_on(cfg_reg.pwm_min_on),
    .i_over_current(sense_reg),
    .o_drive(pwm_drive)
  );

  // Timing ticks
  assign pix_div = cfg_reg.pixel_rate ? PIX_DIV_PIXRATE : PIX_DIV_LINERATE;
  assign pix_tick = (pix_cnt_reg == pix_div - 5'd1);
  // A step size of zero behaves as one
  assign step_last = (cfg_reg.step_size == '0) ? '0 : cfg_reg.step_size - 1'b1;
  assign micro_tick = pix_tick && (step_cnt_reg >= step_last);
  assign full_tick = micro_tick && (sub_reg == MICRO_PER_FULL_M1);
  assign moving = (state_reg == ST_RUN);
  assign powered = (cfg_reg.cmd != CMD_IDLE) && (moving || hold_reg != 5'd0);

  // Full step mode samples the table at the middle of each full step
  assign pos_eff = cfg_reg.micro_mode ? pos_reg : {pos_reg[3:2], 2'b10};
  assign pos_b = cfg_reg.fwd_b_leads ? pos_eff + QUARTER : pos_eff - QUARTER;
  assign idx_a = tri_idx(pos_eff);
  assign idx_b = tri_idx(pos_b);
  assign mag_a = idx_a[3] ? 4'(-idx_a) : 4'(idx_a);
  assign mag_b = idx_b[3] ? 4'(-idx_b) : 4'(idx_b);

  always_comb begin
    state_next = state_reg;
    pix_cnt_next = pix_tick ? 5'd0 : pix_cnt_reg + 5'd1;
    step_cnt_next = step_cnt_reg;
    pos_next = pos_reg;
    sub_next = sub_reg;
    kick_next = kick_reg;
    hold_next = hold_reg;
    moving_next = moving;
    lines_next = lines_reg;
    discard_next = discard_reg;
    sync_next = sync_reg;
    resume_pend_next = resume_pend_reg;
    phase_next = '0;
    fdac_next = DAC_ZERO;
    mdac_next = 2'b00;
    if (pix_tick) begin
      step_cnt_next = micro_tick ? '0 : step_cnt_reg + 1'b1;
    end
    if (micro_tick) begin
      sub_next = sub_reg + 2'd1;
    end
    if (micro_tick && moving) begin
      pos_next = (cfg_reg.cmd == CMD_FEED_REV) ? pos_reg - 4'd1 : pos_reg + 4'd1;
    end
    // Kickstart count loads on each start from rest
    if (moving && !moving_reg) begin
      kick_next = cfg_reg.kick_steps;
    end else if (full_tick && moving && kick_reg != 3'd0) begin
      kick_next = kick_reg - 3'd1;
    end
    if (moving) begin
      hold_next = cfg_reg.hold_steps;
    end else if (full_tick && hold_reg != 5'd0) begin
      hold_next = hold_reg - 5'd1;
    end
    if (state_reg == ST_SYNC_DELAY && pix_tick && sync_reg != '0) begin
      sync_next = sync_reg - 1'b1;
    end
    if (i_line_transfer_pulse && discard_reg != 3'd0) begin
      discard_next = discard_reg - 3'd1;
    end
    case (state_reg)
      ST_IDLE: begin
        if (cfg_reg.cmd != CMD_IDLE) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // Only a scan pauses; feeds carry no lines
        if (i_pause_req && cfg_reg.cmd == CMD_SCAN) begin
          state_next = ST_DRAIN;
          lines_next = cfg_reg.lines_after_pause;
          resume_pend_next = 1'b0;
        end
      end
      ST_DRAIN: begin
        if (i_resume_req) begin
          resume_pend_next = 1'b1;
        end
        if (i_line_transfer_pulse) begin
          if (lines_reg == 3'd0) begin
            state_next = ST_PAUSED;
          end else begin
            lines_next = lines_reg - 3'd1;
          end
        end
      end
      ST_PAUSED: begin
        if (i_resume_req || resume_pend_reg) begin
          state_next = ST_SYNC_WAIT;
          resume_pend_next = 1'b0;
        end
      end
      ST_SYNC_WAIT: begin
        if (i_line_transfer_pulse) begin
          state_next = ST_SYNC_DELAY;
          sync_next = cfg_reg.resync_pixels;
        end
      end
      ST_SYNC_DELAY: begin
        if (sync_reg == '0) begin
          state_next = ST_RUN;
          discard_next = cfg_reg.lines_discard;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (cfg_reg.cmd == CMD_IDLE) begin
      state_next = ST_IDLE;
      hold_next = 5'd0;
      discard_next = 3'd0;
      resume_pend_next = 1'b0;
    end
    // Outputs are registered one cycle behind the position
    if (powered) begin
      if (cfg_reg.micro_mode) begin
        // Positive index drives true side, negative the complement
        phase_next.a = !idx_a[3] && mag_a != 4'd0 && pwm_drive;
        phase_next.a_n = idx_a[3] && pwm_drive;
        phase_next.b = !idx_b[3] && mag_b != 4'd0 && pwm_drive;
        phase_next.b_n = idx_b[3] && pwm_drive;
        mdac_next = (mag_a != 4'd0) ? 2'(mag_a - 4'd1) : 2'b00;
      end else begin
        phase_next.a = !idx_a[3];
        phase_next.a_n = idx_a[3];
        phase_next.b = !idx_b[3];
        phase_next.b_n = idx_b[3];
        if (!moving) begin
          fdac_next = DAC_HOLD;
        end else if (kick_next != 3'd0) begin
          fdac_next = DAC_KICK;
        end else begin
          fdac_next = DAC_SCAN;
        end
      end
    end
    // Idle command or expired hold leaves all drivers off
    if (cfg_reg.cmd == CMD_IDLE) begin
      phase_next = '0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      pix_cnt_reg <= 5'd0;
      step_cnt_reg <= '0;
      pos_reg <= 4'd0;
      sub_reg <= 2'd0;
      kick_reg <= 3'd0;
      hold_reg <= 5'd0;
      moving_reg <= 1'b0;
      lines_reg <= 3'd0;
      discard_reg <= 3'd0;
      sync_reg <= '0;
      resume_pend_reg <= 1'b0;
      phase_reg <= '0;
      fdac_reg <= DAC_ZERO;
      mdac_reg <= 2'b00;
    end else begin
      state_reg <= state_next;
      pix_cnt_reg <= pix_cnt_next;
      step_cnt_reg <= step_cnt_next;
      pos_reg <= pos_next;
      sub_reg <= sub_next;
      kick_reg <= kick_next;
      hold_reg <= hold_next;
      moving_reg <= moving_next;
      lines_reg <= lines_next;
      discard_reg <= discard_next;
      sync_reg <= sync_next;
      resume_pend_reg <= resume_pend_next;
      phase_reg <= phase_next;
      fdac_reg <= fdac_next;
      mdac_reg <= mdac_next;
    end
  end

  assign o_phase_a = phase_reg.a;
  assign o_phase_b = phase_reg.b;
  assign o_phase_a_n = phase_reg.a_n;
  assign o_phase_b_n = phase_reg.b_n;
  assign o_full_dac = fdac_reg;
  assign o_micro_dac = mdac_reg;
  // Lines are kept while running or draining, dropped while stopped
  assign o_line_store = (state_reg == ST_RUN) || (state_reg == ST_DRAIN);
  assign o_line_discard = (discard_reg != 3'd0);

endmodule

// File: test/step_seq_assertions.sv
// Concurrent checks on the stepper sequencer ports
`timescale 1ns/1ps
module step_seq_assertions import step_seq_pkg::*; (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  // Line buffer, timing and current sense
  input wire logic i_pause_req,
  input wire logic i_resume_req,
  input wire logic i_line_transfer_pulse,
  input wire logic i_over_current,
  // Motor driver
  input wire logic o_phase_a,
  input wire logic o_phase_b,
  input wire logic o_phase_a_n,
  input wire logic o_phase_b_n,
  input wire logic [1:0] o_full_dac,
  input wire logic [1:0] o_micro_dac,
  // Line path
  input wire logic o_line_store,
  input wire logic o_line_discard
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic [3:0] ph;
  logic [1:0] pa;
  logic [1:0] pb;
  assign ph = {o_phase_a, o_phase_b, o_phase_a_n, o_phase_b_n};
  assign pa = {o_phase_a, o_phase_a_n};
  assign pb = {o_phase_b, o_phase_b_n};
  sequence acc_s;
    i_psel && i_penable;
  endsequence
  sequence idle_wr_s;
    acc_s ##0 (i_pwrite && i_paddr == {IDX_MOTOR_CTRL, 2'b00} && i_pwdata[1:0] == 2'b00);
  endsequence
  // Powered full step move; a drop to all-off is the hold timeout, not a step
  sequence full_step_s;
    $changed(ph) && ph != 4'h0 && o_full_dac != DAC_ZERO;
  endsequence
  ready_always_a: assert property (o_pready) else $error("ready low");
  err_in_access_a: assert property (o_pslverr |-> acc_s) else $error("error outside access");
  misalign_err_a: assert property (acc_s ##0 (i_paddr[1:0] != 2'b00) |-> o_pslverr) else $error("misaligned taken");
  idle_off_a: assert property (idle_wr_s |-> ##2 (ph == 4'h0 && o_full_dac == DAC_ZERO))
    else $error("idle left outputs on");
  a_pair_excl_a: assert property (!(o_phase_a && o_phase_a_n)) else $error("both A sides on");
  b_pair_excl_a: assert property (!(o_phase_b && o_phase_b_n)) else $error("both B sides on");
  step_spacing_a: assert property (full_step_s |=> (ph == $past(ph) || ph == 4'h0) [*7])
    else $error("full steps too close");
  quad_order_a: assert property (full_step_s ##0 ($past(ph) != 4'h0) |-> !($changed(pa) && $changed(pb)))
    else $error("both windings moved at once");
  pause_freeze_a: assert property (i_pause_req && o_line_store && o_full_dac == DAC_SCAN |-> ##3 ($stable(ph) || ph == 4'h0) [*8])
    else $error("stepping after pause");
  drain_store_a: assert property (i_pause_req && o_line_store |=> o_line_store)
    else $error("current line dropped");
  discard_run_a: assert property ($rose(o_line_discard) |-> ##[0:1] o_line_store)
    else $error("discard without run");
endmodule
bind stepper_motor_step_sequencer step_seq_assertions chk (.*);

// File: test/winding_sense_model.sv
// Winding and sense resistor model on the motor driver side
`timescale 1ns/1ps
module winding_sense_model (
  // Clock
  input wire logic i_sys_clk,
  // Driver levels
  input wire logic [3:0] i_phases,
  input wire logic [1:0] i_level,
  // Sense comparator
  output logic o_over_current = 1'b0
);
  int amps = 0;
  // Current builds fast while driven and decays slowly, so the PWM must trip often
  always @(posedge i_sys_clk) begin
    if (|i_phases) amps <= (amps > 200) ? amps : amps + 4;
    else if (amps > 0) amps <= amps - 1;
    o_over_current <= amps > 4 * (int'(i_level) + 1);
  end
endmodule

// File: test/stepper_motor_step_sequencer_bench.sv
// Self-checking bench for the stepper sequencer
`timescale 1ns/1ps
module stepper_motor_step_sequencer_bench import step_seq_pkg::*;;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_pause_req = 1'b0;
  logic i_resume_req = 1'b0;
  logic i_line_transfer_pulse = 1'b0;
  logic i_over_current;
  logic o_pready, o_pslverr, o_phase_a, o_phase_b, o_phase_a_n, o_phase_b_n, o_line_store, o_line_discard;
  logic [31:0] o_prdata, q;
  logic [1:0] o_full_dac, o_micro_dac;
  logic [3:0] ph, p;
  logic e, seen_an, seen_full;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, chg, top;
  int ctl[3] = '{1, 9, 1};
  int stp[3] = '{1, 1, 2};
  int per[3] = '{32, 96, 64};
  assign ph = {o_phase_a, o_phase_b, o_phase_a_n, o_phase_b_n};
  stepper_motor_step_sequencer DUT (.*);
  winding_sense_model drv (.i_sys_clk(i_sys_clk), .i_phases(ph), .i_level(o_micro_dac), .o_over_current(i_over_current));
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Release costs one idle edge so psel is never driven twice in one step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb({idx, 2'b00}, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb({idx, 2'b00}, 1'b0, 32'h0000_0000);
    check(q, exp);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  task automatic pulse(input int w);
    if (w == 0) i_pause_req <= 1'b1;
    else if (w == 1) i_resume_req <= 1'b1;
    else i_line_transfer_pulse <= 1'b1;
    @(posedge i_sys_clk);
    {i_pause_req, i_resume_req, i_line_transfer_pulse} <= 3'b000;
    @(posedge i_sys_clk);
  endtask
  task automatic gap();
    p = ph;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (ph === p && n < 500);
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    tick(16);
    i_reset <= 1'b0;
    tick(1);
    rd(IDX_MOTOR_CTRL, 32'h0000_0000);
    rd(IDX_STEP_SIZE, 32'h0000_0001);
    rd(IDX_CURRENT, 32'h0000_0100);
    rd(IDX_FWD_PHASE, 32'h0000_0000);
    wr(IDX_PWM_FREQ, 32'h0000_01A5);
    rd(IDX_PWM_FREQ, 32'h0000_00A5);
    apb(12'h1C0, 1'b0, 32'h0000_0000);
    check(q, 32'h0000_0000);
    check(e, 1'b1);
    apb(12'h115, 1'b1, 32'h0000_0001);
    check(e, 1'b1);
    $display("test registers done");
    // Two hold steps keep the hold level past the pause checks whatever the step phase
    wr(IDX_CURRENT, 32'h0000_0202);
    wr(IDX_PAUSE, 32'h0000_0101);
    wr(IDX_RESYNC, 32'h0000_0002);
    wr(IDX_MOTOR_CTRL, 32'h0000_0001);
    tick(12);
    check(o_full_dac, DAC_KICK);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_MOTOR_CTRL, ctl[i]);
      wr(IDX_STEP_SIZE, stp[i]);
      gap();
      gap();
      check(n, per[i]);
    end
    check(o_full_dac, DAC_SCAN);
    wr(IDX_STEP_SIZE, 32'h0000_0001);
    for (int f = 0; f < 2; f++) begin
      wr(IDX_FWD_PHASE, f);
      gap();
      repeat (4) begin
        gap();
        check(p[3] !== ph[3], (p[3] == p[2]) ^ f[0]);
      end
    end
    wr(IDX_MOTOR_CTRL, 32'h0000_0003);
    gap();
    repeat (2) begin
      gap();
      check(p[3] !== ph[3], p[3] == p[2]);
    end
    wr(IDX_MOTOR_CTRL, 32'h0000_0001);
    gap();
    $display("test full step done");
    pulse(0);
    tick(6);
    check(o_full_dac, DAC_HOLD);
    p = ph;
    tick(14);
    check({|ph, ph}, {1'b1, p});
    pulse(2);
    check(o_line_store, 1'b1);
    pulse(2);
    tick(2);
    check(o_line_store, 1'b0);
    tick(40);
    check({ph, o_full_dac}, {4'h0, DAC_ZERO});
    pulse(1);
    tick(4);
    check({ph, o_line_store}, 5'h00);
    pulse(2);
    tick(10);
    check(o_line_store, 1'b0);
    tick(10);
    check({o_line_store, o_line_discard}, 2'b11);
    tick(20);
    check(|ph, 1'b1);
    pulse(2);
    tick(2);
    check(o_line_discard, 1'b0);
    wr(IDX_MOTOR_CTRL, 32'h0000_0000);
    tick(3);
    check({ph, o_full_dac}, {4'h0, DAC_ZERO});
    $display("test pause done");
    wr(IDX_PWM_FREQ, 32'h0000_000F);
    wr(IDX_PWM_MIN_ON, 32'h0000_0002);
    wr(IDX_MOTOR_CTRL, 32'h0000_0005);
    chg = 0;
    top = 0;
    seen_an = 1'b0;
    seen_full = 1'b0;
    p = ph;
    repeat (500) begin
      @(posedge i_sys_clk);
      if (ph !== p) chg++;
      p = ph;
      if (o_micro_dac > top) top = o_micro_dac;
      seen_an |= o_phase_a_n;
      seen_full |= (o_full_dac != DAC_ZERO);
    end
    check({top[1:0], seen_an, seen_full}, 4'hE);
    check(chg > 50, 1'b1);
    wr(IDX_MOTOR_CTRL, 32'h0000_0000);
    tick(3);
    check(ph, 4'h0);
    $display("test microstep done");
    end_of_test();
  end
endmodule
